// File: hdl/drive_pkg.sv
// Constants, register offsets, reset values and carrier types for the drive control block.
// Assumes a single 125 MHz core clock and a one-millisecond control tick derived from it.
package drive_pkg;

  // Clock and control tick.
  localparam int CLK_KHZ      = 125000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = CLK_KHZ * TICK_TIME_US / 1000;

  // Register word offsets on the plain register port.
  localparam logic [4:0] ADDR_REG_SEL   = 5'h00;
  localparam logic [4:0] ADDR_LIMIT     = 5'h01;
  localparam logic [4:0] ADDR_REDUCE    = 5'h02;
  localparam logic [4:0] ADDR_REG_RAMP  = 5'h03;
  localparam logic [4:0] ADDR_TRIP      = 5'h04;
  localparam logic [4:0] ADDR_ACCEL     = 5'h05;
  localparam logic [4:0] ADDR_AO_SEL    = 5'h06;
  localparam logic [4:0] ADDR_SW1_FN    = 5'h07;
  localparam logic [4:0] ADDR_SW2_FN    = 5'h08;
  localparam logic [4:0] ADDR_POT_FN    = 5'h09;
  localparam logic [4:0] ADDR_FILT_SEL  = 5'h0a;
  localparam logic [4:0] ADDR_AO_SCALE  = 5'h0b;
  localparam logic [4:0] ADDR_MAXIMUM_FREQUENCY      = 5'h0c;
  localparam logic [4:0] ADDR_FF5       = 5'h0d;
  localparam logic [4:0] ADDR_CEILING   = 5'h0e;
  localparam logic [4:0] ADDR_STATUS    = 5'h0f;
  localparam logic [4:0] ADDR_FREQ      = 5'h10;
  localparam logic [4:0] ADDR_REF       = 5'h11;

  // Status register bit positions.
  localparam int STAT_MOTOR_ERR = 0;
  localparam int STAT_INV_ERR   = 1;
  localparam int STAT_CLEARED   = 2;

  // Values after reset; currents are in tenths of a percent of inverter rated current.
  localparam logic [15:0] RATED_CURRENT  = 16'h03e8;
  localparam logic [15:0] TRIP_RESET     = RATED_CURRENT;
  localparam logic [15:0] LIMIT_RESET    = 16'h05dc;
  localparam logic [15:0] ACCEL_RESET    = 16'h0014;
  localparam logic [15:0] REG_RAMP_RESET = 16'h0050;
  localparam logic [15:0] MAXIMUM_FREQUENCY_RESET     = 16'h0032;
  localparam logic [15:0] SCALE_RESET    = 16'h0064;
  localparam logic [3:0]  SW1_RESET      = 4'h1;
  localparam logic [3:0]  SW2_RESET      = 4'h7;

  // Scaling: analog output and potentiometer full scale, percent unity.
  localparam logic [9:0]  AO_FULL     = 10'h3ff;
  localparam logic [9:0]  POT_FULL    = 10'h3ff;
  localparam logic [15:0] SCALE_UNITY = 16'h0064;
  localparam logic [31:0] MHZ_PER_HZ  = 32'h0000_03e8;

  // Potentiometer spans, in tenths of a percent.
  localparam logic [31:0] POT_FRED_LOW  = 32'h0000_02bc;
  localparam logic [31:0] POT_FRED_SPAN = 32'h0000_012c;
  localparam logic [31:0] POT_ILIM_LOW  = 32'h0000_012c;
  localparam logic [31:0] POT_ILIM_SPAN = 32'h0000_04b0;
  localparam logic [31:0] PERMILLE      = 32'h0000_03e8;

  // Pulse train output: multiplier and clamps, frequencies in mHz.
  localparam logic [31:0] PULSE_MULT     = 32'h0000_0006;
  localparam logic [31:0] PULSE_LOW_MHZ  = 32'h0000_1388;
  localparam logic [31:0] PULSE_HIGH_MHZ = 32'h0003_f7a0;
  localparam logic [31:0] PULSE_MIN_MHZ  = 32'h0000_7d00;
  localparam logic [31:0] PULSE_MAX_MHZ  = 32'h0017_cdc0;
  localparam logic [63:0] PHASE_GAIN     = (64'h1 << 52) / (64'(CLK_KHZ) * 64'd1000000);

  // Reference filter time constants in tenths of a millisecond, codes 1 to 4.
  localparam int FILT_T1 = 82;
  localparam int FILT_T2 = 246;
  localparam int FILT_T3 = 574;
  localparam int FILT_T4 = 1230;
  localparam int FILT_Q  = 65536 * 10 * TICK_TIME_US / 1000;

  // Regulation selector codes.
  typedef enum logic [1:0] {
    REG_OFF    = 2'b00,
    REG_RETURN = 2'b01,
    REG_STOP   = 2'b10
  } reg_mode_t;

  // Software settings.
  typedef struct packed {
    logic [1:0]       reg_sel;
    logic [15:0]      limit;
    logic [15:0]      reduce;
    logic [15:0]      reg_ramp;
    logic [15:0]      trip;
    logic [15:0]      accel;
    logic [2:0]       ao_sel;
    logic [1:0][3:0]  sw_fn;
    logic [1:0]       pot_fn;
    logic [2:0]       filt_sel;
    logic [15:0]      ao_scale;
    logic [15:0]      maximum_frequency;
    logic [15:0]      ff5;
    logic [15:0]      ceiling;
  } cfg_t;

  // Drive measurements and conditions presented to the block.
  typedef struct packed {
    logic [15:0] app_current;
    logic [15:0] eff_current;
    logic [15:0] eff_power;
    logic        dc_link_high;
    logic        started;
    logic        powered;
    logic        excited;
    logic        dc_hold;
    logic        anticlockwise;
  } drive_meas_t;

endpackage

// File: hdl/drive_control.sv
// Current-limit ramp regulation, overload monitoring and signal outputs of a small inverter.
// Assumes measurements arrive synchronous to core_clk_in and are scaled as the package says.
//
// Contract
// RULE_01 - Selector chooses regulation off, return-to-ramp mode, or ramp-stop mode.
// RULE_02 - Mode 1: current at 75% of limit slows the acceleration ramp.
// RULE_03 - Current above 100% of limit halts acceleration; frequency stops rising.
// RULE_04 - Mode 1: at 125% of limit, frequency drops by reduction frequency.
// RULE_05 - Current back below 100% of limit resumes the normal ramp.
// RULE_06 - Braking is regulated too; frequency may rise up to the ceiling.
// RULE_07 - Mode 1 regulation stays active in steady running, lowering speed.
// RULE_08 - Mode 2: above 125% the ramp only holds, no frequency reduction.
// RULE_09 - Operator should set regulation ramp near four times acceleration ramp.
// RULE_10 - Current over motor trip setting trips after preset time, motor error.
// RULE_11 - A second monitor trips at rated current with inverter error.
// RULE_12 - Motor trip current resets to 100% of rated current.
// RULE_13 - Analog code 0 gives zero; code 1 gives frequency over full scale.
// RULE_14 - Code 2 goes high on high dc link while started, under 1 kHz.
// RULE_15 - Code 3 is square wave at six times frequency, clamped 32-1560 Hz.
// RULE_16 - Codes 4-6 scale current 200%, effective current and power 100%.
// RULE_17 - Switch codes 0-6: low, healthy, excited, direction, zero, reference reached.
// RULE_18 - Code 7 above fixed frequency five, 8 above 110% trip, 10 cleared.
// RULE_19 - Switch outputs reset to function codes 1 and 7.
// RULE_20 - Potentiometer sets reference, maximum frequency 70-100%, or limit 30-150%.
// RULE_21 - Reference input is low-pass filtered with five selectable time constants; the code has four, codes 1 to 4, and other codes pass unfiltered.
// RULE_22 - Analog value is multiplied by the scale factor, then saturated at full.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

module drive_control
  import drive_pkg::*;
#(
  parameter int          TICK_COUNT      = TICK_CYCLES,
  parameter logic [31:0] OVERLOAD_BUDGET = 32'h005b_8d80
) (
  // Clock and reset.
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // Register port.
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // Drive measurements and inputs.
  input  wire drive_meas_t meas_in,
  input  wire logic [9:0]  analog_reference_in,
  input  wire logic [9:0]  potentiometer_in,
  // Drive outputs.
  output logic      [23:0] output_frequency_out,
  output logic             motor_overload_error_out,
  output logic             inverter_overload_error_out,
  output logic      [9:0]  analog_level_out,
  output logic             analog_pin_out,
  output logic      [1:0]  switch_out
);

  typedef struct packed {
    cfg_t        cfg;
    logic [16:0] tick_cnt;
    logic [23:0] freq;
    logic        over_hi;
    logic [31:0] filt;
    logic [31:0] motor_acc;
    logic [31:0] inv_acc;
    logic        err_motor;
    logic        err_inv;
    logic        cleared;
    logic        dc_high;
    logic [9:0]  ao_level;
    logic        ao_pin;
    logic [9:0]  pwm_cnt;
    logic [31:0] phase;
    logic [1:0]  sw;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // Value over full scale as an analog code, saturated; a zero full scale reads as zero.
  function automatic logic [9:0] frac(input logic [31:0] value, input logic [31:0] full);
    logic [63:0] q;
    q = 64'h0;
    if (full != 32'h0) begin
      q = (64'(value) * 64'(AO_FULL)) / 64'(full);
    end
    return (q > 64'(AO_FULL)) ? AO_FULL : q[9:0];
  endfunction

  // One millisecond step of a current-time integrator; falls back when under the trip level.
  function automatic logic [31:0] integrate(input logic [31:0] acc, input logic [15:0] cur,
                                            input logic [15:0] trip);
    logic [32:0] sum;
    sum = 33'h0;
    if (cur > trip) begin
      sum = 33'(acc) + 33'(cur - trip);
      return sum[32] ? 32'hffff_ffff : sum[31:0];
    end
    return (acc > 32'(trip - cur)) ? acc - 32'(trip - cur) : 32'h0;
  endfunction

  // Filter gain in Q16 for each time constant code.
  function automatic logic [31:0] filt_gain(input logic [2:0] code);
    case (code)
      3'h1: return 32'(FILT_Q / FILT_T1);
      3'h2: return 32'(FILT_Q / FILT_T2);
      3'h3: return 32'(FILT_Q / FILT_T3);
      3'h4: return 32'(FILT_Q / FILT_T4);
      default: return 32'h0001_0000;
    endcase
  endfunction

  logic        tick;
  logic [31:0] cur;
  logic [31:0] lim;
  logic [31:0] maximum_frequency_mhz;
  logic [31:0] maximum_frequency_eff;
  logic [31:0] ceil_mhz;
  logic [31:0] ref_code;
  logic [31:0] target;
  logic [31:0] freq;
  logic [31:0] step;
  logic        hi;
  logic        ov;
  logic        mid;
  logic        active;
  logic [63:0] wide;
  logic [31:0] pulse_mhz;
  logic [9:0]  raw;
  logic [47:0] scaled;
  logic [63:0] fdiff;
  logic [15:0] flags;

  always_comb begin
    next_st   = st;
    tick      = (st.tick_cnt == 17'(TICK_COUNT - 1));
    cur       = 32'(meas_in.app_current);
    freq      = 32'(st.freq);
    maximum_frequency_mhz  = 32'(st.cfg.maximum_frequency) * MHZ_PER_HZ;
    wide      = 64'h0;
    pulse_mhz = 32'h0;
    raw       = 10'h0;
    fdiff     = 64'h0;

    // Control tick counter.
    next_st.tick_cnt = tick ? 17'h0 : st.tick_cnt + 17'h1;

    // Potentiometer may lower the maximum frequency or set the current limit.
    maximum_frequency_eff = maximum_frequency_mhz;
    lim      = 32'(st.cfg.limit);
    if (st.cfg.pot_fn == 2'h1) begin
      wide     = 64'(maximum_frequency_mhz) * 64'(POT_FRED_LOW + POT_FRED_SPAN * 32'(potentiometer_in)
                 / 32'(POT_FULL));
      maximum_frequency_eff = 32'(wide / 64'(PERMILLE)); // RULE_20
    end else if (st.cfg.pot_fn == 2'h2) begin
      lim = POT_ILIM_LOW + POT_ILIM_SPAN * 32'(potentiometer_in) / 32'(POT_FULL); // RULE_20
    end
    ceil_mhz = (st.cfg.ceiling == 16'h0) ? maximum_frequency_mhz : 32'(st.cfg.ceiling) * MHZ_PER_HZ;

    // Reference: potentiometer in mode 0, otherwise the filtered analog input.
    ref_code = (st.cfg.pot_fn == 2'h0) ? 32'(potentiometer_in) : 32'(st.filt[25:16]); // RULE_20
    wide     = 64'(maximum_frequency_eff) * 64'(ref_code) / 64'(POT_FULL);
    target   = meas_in.started ? 32'(wide) : 32'h0;
    if (target > ceil_mhz) begin
      target = ceil_mhz;
    end

    // Low-pass filter on the reference input, updated each tick.
    if (tick) begin
      fdiff = (64'(analog_reference_in) << 16) - 64'(st.filt);
      fdiff = $signed(fdiff) * $signed({32'h0, filt_gain(st.cfg.filt_sel)});
      next_st.filt = st.filt + 32'($signed(fdiff) >>> 16); // RULE_21
    end

    // Current thresholds against the limit: 75, 100 and 125 percent.
    hi     = (cur * 32'h4) > (lim * 32'h5);
    ov     = cur > lim;
    mid    = (cur * 32'h4) >= (lim * 32'h3);
    active = (st.cfg.reg_sel != REG_OFF) &&
             ((freq != target) || (st.cfg.reg_sel == REG_RETURN)); // RULE_01 RULE_07
    step   = 32'(st.cfg.accel);

    // Frequency ramp with current-limit regulation.
    if (st.err_motor || st.err_inv) begin
      freq = 32'h0;
    end else if (tick) begin
      next_st.over_hi = hi;
      if (active && hi && (st.cfg.reg_sel == REG_RETURN) && !st.over_hi) begin
        freq = (freq > 32'(st.cfg.reduce) * MHZ_PER_HZ) ?
               freq - 32'(st.cfg.reduce) * MHZ_PER_HZ : 32'h0; // RULE_04
      end else if (active && ov) begin
        if (freq > target) begin
          freq = freq + 32'(st.cfg.reg_ramp); // RULE_06
          if (freq > ceil_mhz) begin
            freq = ceil_mhz; // RULE_06
          end
        end else if (freq == target) begin
          freq = (freq > 32'(st.cfg.reg_ramp)) ? freq - 32'(st.cfg.reg_ramp) : 32'h0; // RULE_07
        end
        // Accelerating over the limit: frequency is held in both modes. RULE_03 RULE_08
      end else begin
        if ((st.cfg.reg_sel == REG_RETURN) && mid) begin
          step = step >> 1; // RULE_02
        end
        if (freq < target) begin
          freq = (target - freq > step) ? freq + step : target; // RULE_05
        end else if (freq > target) begin
          freq = (freq - target > step) ? freq - step : target;
        end
      end
    end

    next_st.freq = 24'(freq);

    // Current-time monitors for motor and inverter.
    if (tick) begin
      next_st.motor_acc = integrate(st.motor_acc, meas_in.app_current, st.cfg.trip); // RULE_10
      next_st.inv_acc   = integrate(st.inv_acc, meas_in.app_current, RATED_CURRENT); // RULE_11
    end

    // Register port: writes, error acknowledge and read data one cycle later.
    next_st.rdata = 32'h0;
    if (reg_write_in) begin
      unique case (reg_addr_in)
        ADDR_REG_SEL:  next_st.cfg.reg_sel  = reg_wdata_in[1:0];
        ADDR_LIMIT:    next_st.cfg.limit    = reg_wdata_in[15:0];
        ADDR_REDUCE:   next_st.cfg.reduce   = reg_wdata_in[15:0];
        ADDR_REG_RAMP: next_st.cfg.reg_ramp = reg_wdata_in[15:0];
        ADDR_TRIP:     next_st.cfg.trip     = reg_wdata_in[15:0];
        ADDR_ACCEL:    next_st.cfg.accel    = reg_wdata_in[15:0];
        ADDR_AO_SEL:   next_st.cfg.ao_sel   = reg_wdata_in[2:0];
        ADDR_SW1_FN:   next_st.cfg.sw_fn[0] = reg_wdata_in[3:0];
        ADDR_SW2_FN:   next_st.cfg.sw_fn[1] = reg_wdata_in[3:0];
        ADDR_POT_FN:   next_st.cfg.pot_fn   = reg_wdata_in[1:0];
        ADDR_FILT_SEL: next_st.cfg.filt_sel = reg_wdata_in[2:0];
        ADDR_AO_SCALE: next_st.cfg.ao_scale = reg_wdata_in[15:0];
        ADDR_MAXIMUM_FREQUENCY:     next_st.cfg.maximum_frequency     = reg_wdata_in[15:0];
        ADDR_FF5:      next_st.cfg.ff5      = reg_wdata_in[15:0];
        ADDR_CEILING:  next_st.cfg.ceiling  = reg_wdata_in[15:0];
        ADDR_STATUS: begin
          if (reg_wdata_in[STAT_MOTOR_ERR] && (st.err_motor || st.err_inv)) begin
            next_st.err_motor = 1'b0;
            next_st.err_inv   = 1'b0;
            next_st.motor_acc = 32'h0;
            next_st.inv_acc   = 32'h0;
            next_st.cleared   = 1'b1;
          end
        end
        default: ;
      endcase
    end

    if (reg_read_in) begin
      unique case (reg_addr_in)
        ADDR_REG_SEL:  next_st.rdata = 32'(st.cfg.reg_sel);
        ADDR_LIMIT:    next_st.rdata = 32'(st.cfg.limit);
        ADDR_REDUCE:   next_st.rdata = 32'(st.cfg.reduce);
        ADDR_REG_RAMP: next_st.rdata = 32'(st.cfg.reg_ramp);
        ADDR_TRIP:     next_st.rdata = 32'(st.cfg.trip);
        ADDR_ACCEL:    next_st.rdata = 32'(st.cfg.accel);
        ADDR_AO_SEL:   next_st.rdata = 32'(st.cfg.ao_sel);
        ADDR_SW1_FN:   next_st.rdata = 32'(st.cfg.sw_fn[0]);
        ADDR_SW2_FN:   next_st.rdata = 32'(st.cfg.sw_fn[1]);
        ADDR_POT_FN:   next_st.rdata = 32'(st.cfg.pot_fn);
        ADDR_FILT_SEL: next_st.rdata = 32'(st.cfg.filt_sel);
        ADDR_AO_SCALE: next_st.rdata = 32'(st.cfg.ao_scale);
        ADDR_MAXIMUM_FREQUENCY:     next_st.rdata = 32'(st.cfg.maximum_frequency);
        ADDR_FF5:      next_st.rdata = 32'(st.cfg.ff5);
        ADDR_CEILING:  next_st.rdata = 32'(st.cfg.ceiling);
        ADDR_STATUS:   next_st.rdata = {29'h0, st.cleared, st.err_inv, st.err_motor};
        ADDR_FREQ:     next_st.rdata = 32'(st.freq);
        ADDR_REF:      next_st.rdata = 32'(st.filt[25:16]);
        default:       next_st.rdata = 32'h0;
      endcase
    end

    // Trips are set after the clear, so a trip in the acknowledge cycle is kept.
    if (st.motor_acc >= OVERLOAD_BUDGET) begin
      next_st.err_motor = 1'b1; // RULE_10
      next_st.cleared   = 1'b0;
    end
    if (st.inv_acc >= OVERLOAD_BUDGET) begin
      next_st.err_inv = 1'b1; // RULE_11
      next_st.cleared = 1'b0;
    end

    // Braking chopper level is refreshed only per tick to keep toggling well under 1 kHz.
    if (tick) begin
      next_st.dc_high = meas_in.dc_link_high && meas_in.started; // RULE_14
    end

    // Pulse train frequency: six times output, clamped at both ends.
    if (freq < PULSE_LOW_MHZ) begin
      pulse_mhz = PULSE_MIN_MHZ; // RULE_15
    end else if (freq > PULSE_HIGH_MHZ) begin
      pulse_mhz = PULSE_MAX_MHZ; // RULE_15
    end else begin
      pulse_mhz = freq * PULSE_MULT; // RULE_15
    end

    wide          = (64'(pulse_mhz) * PHASE_GAIN) >> 20;
    next_st.phase = st.phase + wide[31:0];

    // Analog output selection, then scale factor with saturation.
    unique case (st.cfg.ao_sel)
      3'h1: raw = frac(32'(st.freq), maximum_frequency_mhz); // RULE_13
      3'h2: raw = st.dc_high ? AO_FULL : 10'h0; // RULE_14
      3'h3: raw = st.phase[31] ? AO_FULL : 10'h0; // RULE_15
      3'h4: raw = frac(32'(meas_in.app_current), 32'(RATED_CURRENT) * 32'h2); // RULE_16
      3'h5: raw = frac(32'(meas_in.eff_current), 32'(RATED_CURRENT)); // RULE_16
      3'h6: raw = frac(32'(meas_in.eff_power), 32'(RATED_CURRENT)); // RULE_16
      default: raw = 10'h0; // RULE_13
    endcase
    scaled = 48'(raw) * 48'(st.cfg.ao_scale) / 48'(SCALE_UNITY);
    next_st.ao_level = (scaled > 48'(AO_FULL)) ? AO_FULL : scaled[9:0]; // RULE_22
    next_st.pwm_cnt  = (st.pwm_cnt == AO_FULL - 10'h1) ? 10'h0 : st.pwm_cnt + 10'h1;

    // Digital codes drive the pin directly; the others use the duty cycle of the level.
    if ((st.cfg.ao_sel == 3'h2) || (st.cfg.ao_sel == 3'h3)) begin
      next_st.ao_pin = raw[0]; // RULE_14 RULE_15
    end else begin
      next_st.ao_pin = st.ao_level > st.pwm_cnt; // RULE_22
    end

    // Switching output conditions indexed by function code.
    flags     = 16'h0;
    flags[1]  = meas_in.powered && !st.err_motor && !st.err_inv;
    flags[2]  = meas_in.excited;
    flags[3]  = (meas_in.anticlockwise && (st.freq != 24'h0)) || meas_in.dc_hold;
    flags[4]  = (!meas_in.anticlockwise && (st.freq != 24'h0)) || meas_in.dc_hold;
    flags[5]  = (st.freq == 24'h0);
    flags[6]  = meas_in.started && (freq == target);
    flags[7]  = 32'(st.freq) > 32'(st.cfg.ff5) * MHZ_PER_HZ;
    flags[8]  = (cur * 32'ha) > (32'(st.cfg.trip) * 32'hb);
    flags[10] = st.cleared;

    for (int i = 0; i < 2; i++) begin
      next_st.sw[i] = flags[st.cfg.sw_fn[i]]; // RULE_17 RULE_18
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st                <= '0;
      st.cfg.limit      <= LIMIT_RESET;
      st.cfg.reg_ramp   <= REG_RAMP_RESET;
      st.cfg.trip       <= TRIP_RESET; // RULE_12
      st.cfg.accel      <= ACCEL_RESET;
      st.cfg.sw_fn[0]   <= SW1_RESET; // RULE_19
      st.cfg.sw_fn[1]   <= SW2_RESET; // RULE_19
      st.cfg.ao_scale   <= SCALE_RESET;
      st.cfg.maximum_frequency       <= MAXIMUM_FREQUENCY_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from state flip-flops.
  assign reg_rdata_out               = st.rdata;
  assign output_frequency_out        = st.freq;
  assign motor_overload_error_out    = st.err_motor;
  assign inverter_overload_error_out = st.err_inv;
  assign analog_level_out            = st.ao_level;
  assign analog_pin_out              = st.ao_pin;
  assign switch_out                  = st.sw;

endmodule

`default_nettype wire

// File: bench/drive_motor_model.sv
// Motor and wiring stand-in: turns a commanded load and wiring states into measurements.
// Assumes the bench sets load and flags; answers one clock later, like a sampled sensor.
`timescale 1ns/100ps
`default_nettype none
module drive_motor_model
  import drive_pkg::*;
(
  // Clock, load and wiring states.
  input  wire logic [0:0]  clk_in,
  input  wire logic [15:0] load_in,
  input  wire logic [5:0]  flags_in,
  // Measurements.
  output var  drive_meas_t meas_out
);
  // Effective current and power follow half the apparent current, as at a fixed power factor.
  always_ff @(posedge clk_in) begin
    meas_out <= {load_in, load_in >> 1, load_in >> 1, flags_in};
  end
endmodule
`default_nettype wire

// File: bench/drive_control_assertions.sv
// Checker for drive_control: register port timing and overload trip behaviour.
// Assumes the bind below; it sees only the block's ports.
`timescale 1ns/100ps
`default_nettype none
module drive_control_assertions
  import drive_pkg::*;
(
  // Clock, reset and register port.
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic [4:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  // Drive outputs.
  input wire logic [23:0] output_frequency_out,
  input wire logic        motor_overload_error_out,
  input wire logic        inverter_overload_error_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Only a status write with bit 0 set may drop an error, so the trips cannot self-heal.
  logic       clr;
  logic [1:0] errs;
  assign clr = reg_write_in && reg_addr_in == ADDR_STATUS && reg_wdata_in[0];
  assign errs = {inverter_overload_error_out, motor_overload_error_out};
  property p_rd_idle; !reg_read_in |=> reg_rdata_out == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
  property p_rd_unmapped; reg_read_in && reg_addr_in > ADDR_REF |=> reg_rdata_out == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_narrow; reg_read_in && reg_addr_in == ADDR_SW1_FN |=> reg_rdata_out[31:4] == 28'h0;
  endproperty
  a_rd_narrow: assert property (p_rd_narrow) else $error("upper bits set");
  property p_rd_status; reg_read_in && reg_addr_in == ADDR_STATUS
    |=> reg_rdata_out[1:0] == $past(errs); endproperty
  a_rd_status: assert property (p_rd_status) else $error("status bits wrong");
  property p_rd_freq; reg_read_in && reg_addr_in == ADDR_FREQ
    |=> reg_rdata_out == {8'h0, $past(output_frequency_out)}; endproperty
  a_rd_freq: assert property (p_rd_freq) else $error("frequency read wrong");
  property p_mot_hold; motor_overload_error_out && !clr |=> motor_overload_error_out; endproperty
  a_mot_hold: assert property (p_mot_hold) else $error("motor error dropped");
  property p_inv_hold; errs[1] && !clr |=> errs[1]; endproperty
  a_inv_hold: assert property (p_inv_hold) else $error("inverter error dropped");
  property p_trip_stop; $rose(|errs) |=> output_frequency_out == 24'h0; endproperty
  a_trip_stop: assert property (p_trip_stop) else $error("trip left output running");
endmodule
bind drive_control drive_control_assertions u_drive_control_assertions (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out), .output_frequency_out(output_frequency_out),
  .motor_overload_error_out(motor_overload_error_out),
  .inverter_overload_error_out(inverter_overload_error_out));
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench: ramp regulation, overload trips, analog and switching outputs.
// Assumes a short control tick and overload budget so the run stays brief.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import drive_pkg::*;
  localparam int T = 20;
  localparam int P = 40;
  localparam int S = 99999;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, merr, ierr;
  logic [4:0] addr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [15:0] load = '0, lfsr = 16'h000b;
  logic [5:0] flags = '0;
  logic [9:0] rlv = '0, level;
  logic [23:0] freq, fa, fb = '0;
  logic [1:0] sw;
  drive_meas_t meas;
  int errors = 0, num_checks = 0, cyc = 0;
  int sel[9] = '{0, 0, 1, 1, 1, 2, 2, 1, 1};
  int cur[9] = '{0, 1600, 1200, 1600, 2000, 2000, 0, 1600, 0};
  int set[9] = '{S, S, S, S, -1000, 0, S, S, S};
  int slope[9] = '{400, 400, 200, 0, 0, 0, 400, 1600, -400};
  int asel[4] = '{4, 5, 6, 0};
  int ascl[4] = '{50, 200, 100, 100};
  int aexp[4] = '{511, 1023, 1023, 0};
  // The cycle count lets frequency samples sit a whole number of ticks apart.
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  drive_control #(.TICK_COUNT(T), .OVERLOAD_BUDGET(32'h0000_ffff)) u_drive_control (
    .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(we), .reg_read_in(re), .reg_rdata_out(rdata), .meas_in(meas),
    .analog_reference_in(rlv), .potentiometer_in(rlv), .output_frequency_out(freq),
    .motor_overload_error_out(merr), .inverter_overload_error_out(ierr),
    .analog_level_out(level), .analog_pin_out(), .switch_out(sw));
  drive_motor_model u_drive_motor_model (.clk_in(clk), .load_in(load), .flags_in(flags),
    .meas_out(meas));
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Switch level expected with frequency at zero, errors cleared and trip at rated current.
  function automatic logic swx(input int c);
    case (c)
      1: return flags[3];
      2: return flags[2];
      3, 4: return flags[1];
      5, 10: return 1'b1;
      8: return load * 10 > 11000;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic align();
    @(negedge clk);
    while (cyc % P != 0) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog sized well above the longest overload wait.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    flags <= 6'h18;
    rd(ADDR_TRIP);
    chk("trip", d, 32'h3e8);
    rd(ADDR_SW1_FN);
    chk("sw1", d, 32'h1);
    rd(ADDR_SW2_FN);
    chk("sw2", d, 32'h7);
    rd(5'h1f);
    chk("unmapped", d, '0);
    chk("sw", 32'(sw), 32'h1);
    wr(ADDR_ACCEL, 32'h0000_00c8);
    wr(ADDR_REG_RAMP, 32'h0000_0320);
    wr(ADDR_REDUCE, 32'h1);
    rlv <= 10'h3ff;
    // Each entry: a transition interval, then a steady interval of two ticks.
    for (int i = 0; i < 9; i++) begin
      load <= 16'(cur[i]);
      if (i == 7) rlv <= '0;
      wr(ADDR_REG_SEL, sel[i]);
      align();
      fa = freq;
      if (set[i] != S) chk("settle", 32'(fa) - 32'(fb), set[i]);
      align();
      fb = freq;
      chk("slope", 32'(fb) - 32'(fa), slope[i]);
    end
    rd(ADDR_FREQ);
    load <= 16'h07d0;
    foreach (asel[i]) begin
      wr(ADDR_AO_SCALE, ascl[i]);
      wr(ADDR_AO_SEL, asel[i]);
      repeat (T + 4) @(negedge clk);
      chk("analog", 32'(level), aexp[i]);
    end
    wr(ADDR_TRIP, 32'h0000_09c4);
    for (int n = 0; n < 5000 && ierr !== 1'b1; n++) @(negedge clk);
    chk("inverter", 32'({merr, ierr}), 32'h1);
    load <= '0;
    repeat (2) wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS);
    chk("clear", d, 32'h4);
    wr(ADDR_TRIP, 32'h0000_01f4);
    load <= 16'h03e8;
    for (int n = 0; n < 5000 && merr !== 1'b1; n++) @(negedge clk);
    chk("motor", 32'({merr, ierr}), 32'h2);
    rd(ADDR_STATUS);
    chk("status", d, 32'h1);
    load <= '0;
    rlv <= '0;
    repeat (2) wr(ADDR_STATUS, 32'h1);
    wr(ADDR_TRIP, 32'h0000_03e8);
    // Random wiring states and currents against switch function codes 0 to 10.
    for (int i = 0; i < 22; i++) begin
      lfsr = step(lfsr);
      flags <= {lfsr[5], 1'b0, lfsr[3:0]};
      load <= {5'h00, lfsr[15:5]};
      wr(ADDR_SW2_FN, 32'(i % 11));
      repeat (3) @(negedge clk);
      chk("switch", 32'(sw), {30'h0, swx(i % 11), flags[3]});
    end
    complete_run();
  end
endmodule
`default_nettype wire
